// ### hw/scr_regs.sv
// System-control register bank of the core, reached over AXI4-Lite.
// Assumes core events arrive on clk_sys; strap pins are asynchronous.
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps

module scr_regs #(
    parameter int          ADDR_W   = 8,
    parameter logic [7:0]  REV_MAJ  = 8'h01,
    parameter logic [7:0]  REV_MIN  = 8'h00,
    parameter logic [15:0] IMP_CODE = 16'h00a5  // Arbitrary implementation code
) (
    input  wire logic                        clk_sys,
    input  wire logic                        reset,
    input  wire logic [ADDR_W-1:0]           s_axi_awaddr,
    input  wire logic                        s_axi_awvalid,
    output logic                             s_axi_awready,
    input  wire logic [31:0]                 s_axi_wdata,
    input  wire logic [3:0]                  s_axi_wstrb,
    input  wire logic                        s_axi_wvalid,
    output logic                             s_axi_wready,
    output logic [1:0]                       s_axi_bresp,
    output logic                             s_axi_bvalid,
    input  wire logic                        s_axi_bready,
    input  wire logic [ADDR_W-1:0]           s_axi_araddr,
    input  wire logic                        s_axi_arvalid,
    output logic                             s_axi_arready,
    output logic [31:0]                      s_axi_rdata,
    output logic [1:0]                       s_axi_rresp,
    output logic                             s_axi_rvalid,
    input  wire logic                        s_axi_rready,
    input  wire logic                        sixteen_isa_strap,
    input  wire logic [2:0]                  clock_ratio_strap,
    input  wire scr_pkg::scr_exc_event_type  exc_event,
    input  wire scr_pkg::scr_miss_event_type miss_event,
    input  wire scr_pkg::scr_mem_access_type mem_access,
    output logic [63:0]                      exc_return_addr,
    output logic                             sixteen_bit_isa_enabled,
    output logic                             kseg0_uncached,
    output logic                             watch_exception
);

    // ************************************************************
    // Elaboration checks
    // ************************************************************
    if (ADDR_W < 7 || ADDR_W > 32) begin : g_bad_addr_w
        $error("ADDR_W must cover all register slots and fit 32 bits");
    end

    // ************************************************************
    // State
    // ************************************************************
    typedef struct packed {
        logic [1:0]  strap_sync1;
        logic [1:0]  strap_sync2;
        logic [2:0]  ratio_sync1;
        logic [2:0]  ratio_sync2;
        logic [1:0]  cap_cnt;
        logic        sixteen_bit_isa_enabled;
        logic [2:0]  sys_clock_ratio;
        logic [3:0]  writeback_pattern;
        logic        accel_data;
        logic [2:0]  kseg_zero_coherency;
        logic [63:0] exc_return_addr;
        logic [31:0] linked_load_phys;
        logic [31:0] watch_low_reg;
        logic [31:0] watch_high_reg;
        logic [28:0] page_table_base;
        logic [1:0]  xc_region;
        logic [28:0] faulting_vpage_pair;
        logic        aw_have;
        logic [5:0]  aw_idx;
        logic        aw_bad;
        logic        w_have;
        logic [31:0] w_data;
        logic [3:0]  w_strb;
        logic        awready;
        logic        wready;
        logic        bvalid;
        logic [1:0]  bresp;
        logic        arready;
        logic        rvalid;
        logic [31:0] rdata;
        logic [1:0]  rresp;
        logic        kseg0_uncached;
        logic        watch_exception;
    } scr_state_type;

    scr_state_type state_reg;
    scr_state_type state_next;

    // Byte-lane merge of a write into a 32-bit word
    function automatic logic [31:0] merge(input logic [31:0] old_w, input logic [31:0] new_w,
                                          input logic [3:0] strb);
        logic [31:0] res;
        res = old_w;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) begin
                res[8*i +: 8] = new_w[8*i +: 8];
            end
        end
        return res;
    endfunction

    // Word index of a byte address; flags addresses beyond the slot range
    function automatic logic [6:0] decode(input logic [ADDR_W-1:0] addr);
        logic [ADDR_W-1:0] idx;
        idx = addr >> 2;
        return {(idx > ADDR_W'(scr_pkg::IDX_EPC_HI)), idx[5:0]};
    endfunction

    // Mapped slot test
    function automatic logic mapped(input logic [5:0] idx);
        return idx >= scr_pkg::IDX_EPC_LO && idx <= scr_pkg::IDX_EPC_HI;
    endfunction

    logic [31:0] cfg_word;
    logic [31:0] revision_identifier_word;
    logic [63:0] xctx_word;
    logic [6:0]  ar_dec;
    logic [6:0]  aw_dec;
    logic [32:0] watch_addr;
    logic        watch_hit;

    // ************************************************************
    // Read views of composite registers
    // ************************************************************
    always_comb begin
        cfg_word = scr_pkg::CFG_ONES;
        cfg_word[scr_pkg::CFG_EC_POS +: 3]  = state_reg.sys_clock_ratio;
        cfg_word[scr_pkg::CFG_EP_POS +: 4]  = state_reg.writeback_pattern;
        cfg_word[scr_pkg::CFG_AD_POS]       = state_reg.accel_data;
        cfg_word[scr_pkg::CFG_M16_POS]      = state_reg.sixteen_bit_isa_enabled;
        cfg_word[scr_pkg::CFG_BE_POS]       = scr_pkg::ENDIAN_LITTLE;
        cfg_word[scr_pkg::CFG_IC_POS +: 3]  = scr_pkg::CACHE_CODE;
        cfg_word[scr_pkg::CFG_DC_POS +: 3]  = scr_pkg::CACHE_CODE;
        cfg_word[2:0]                       = state_reg.kseg_zero_coherency;
        revision_identifier_word = {IMP_CODE, REV_MAJ[3:0], REV_MIN[3:0], 8'h00} >> 8;
        revision_identifier_word[7:0] = {REV_MAJ[3:0], REV_MIN[3:0]};
        revision_identifier_word[15:8] = IMP_CODE[7:0];
        revision_identifier_word[31:16] = 16'h0000;
        xctx_word = {state_reg.page_table_base, state_reg.xc_region,
                     state_reg.faulting_vpage_pair, 4'h0};
        ar_dec = decode(s_axi_araddr);
        aw_dec = decode(s_axi_awaddr);
        watch_addr = {state_reg.watch_high_reg[3:0], state_reg.watch_low_reg[31:3]};
        watch_hit = mem_access.valid && (mem_access.paddr[35:3] == watch_addr)
                    && ((mem_access.is_load && state_reg.watch_low_reg[scr_pkg::WLO_RD_BIT])
                     || (mem_access.is_store && state_reg.watch_low_reg[scr_pkg::WLO_WR_BIT]));
    end

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb begin
        logic [31:0] cw;
        cw = scr_pkg::ZERO32;
        state_next = state_reg;

        // Strap synchronisers and one-time capture after reset release
        state_next.strap_sync1 = {sixteen_isa_strap, 1'b0};
        state_next.strap_sync2 = state_reg.strap_sync1;
        state_next.ratio_sync1 = clock_ratio_strap;
        state_next.ratio_sync2 = state_reg.ratio_sync1;
        if (state_reg.cap_cnt != scr_pkg::SYNC_DONE) begin
            state_next.cap_cnt = state_reg.cap_cnt + 2'h1;
            // Second flop holds the strap from the second edge after release; capture is on the third
            if (state_reg.cap_cnt == scr_pkg::SYNC_DONE - 2'h1) begin
                state_next.sixteen_bit_isa_enabled = state_reg.strap_sync2[1];
                state_next.sys_clock_ratio = state_reg.ratio_sync2;
            end
        end

        // Write channel acceptance, either order
        if (s_axi_awvalid && state_reg.awready) begin
            state_next.aw_have = 1'b1;
            state_next.aw_idx  = aw_dec[5:0];
            state_next.aw_bad  = aw_dec[6] || !mapped(aw_dec[5:0]);
        end
        if (s_axi_wvalid && state_reg.wready) begin
            state_next.w_have = 1'b1;
            state_next.w_data = s_axi_wdata;
            state_next.w_strb = s_axi_wstrb;
        end
        if (state_reg.bvalid && s_axi_bready) begin
            state_next.bvalid = 1'b0;
        end

        // Register update once both halves are held
        if (state_reg.aw_have && state_reg.w_have && !state_reg.bvalid) begin
            state_next.aw_have = 1'b0;
            state_next.w_have  = 1'b0;
            state_next.bvalid  = 1'b1;
            state_next.bresp   = state_reg.aw_bad ? scr_pkg::RESP_SLVERR : scr_pkg::RESP_OKAY;
            if (!state_reg.aw_bad) begin
                case (state_reg.aw_idx)
                    scr_pkg::IDX_EPC_LO: begin
                        state_next.exc_return_addr[31:0] =
                            merge(state_reg.exc_return_addr[31:0], state_reg.w_data, state_reg.w_strb);
                    end
                    scr_pkg::IDX_EPC_HI: begin
                        state_next.exc_return_addr[63:32] =
                            merge(state_reg.exc_return_addr[63:32], state_reg.w_data, state_reg.w_strb);
                    end
                    scr_pkg::IDX_CONFIG: begin
                        cw = merge(cfg_word, state_reg.w_data, state_reg.w_strb);
                        state_next.writeback_pattern   = cw[scr_pkg::CFG_EP_POS +: 4];
                        state_next.accel_data          = cw[scr_pkg::CFG_AD_POS];
                        state_next.kseg_zero_coherency = cw[2:0];
                    end
                    scr_pkg::IDX_LINKED_LOAD_PHYS: begin
                        state_next.linked_load_phys =
                            merge(state_reg.linked_load_phys, state_reg.w_data, state_reg.w_strb);
                    end
                    scr_pkg::IDX_WATCH_LOW_REG: begin
                        state_next.watch_low_reg =
                            merge(state_reg.watch_low_reg, state_reg.w_data, state_reg.w_strb);
                    end
                    scr_pkg::IDX_WATCH_HIGH_REG: begin
                        state_next.watch_high_reg =
                            merge(state_reg.watch_high_reg, state_reg.w_data, state_reg.w_strb);
                    end
                    scr_pkg::IDX_XCTX_HI: begin
                        cw = merge(xctx_word[63:32], state_reg.w_data, state_reg.w_strb);
                        state_next.page_table_base = cw[31:3];
                    end
                    default: begin
                        cw = scr_pkg::ZERO32;  // Read-only slots ignore writes
                    end
                endcase
            end
        end

        // Hardware captures win over a same-cycle software write
        if (exc_event.valid) begin
            if (!state_reg.sixteen_bit_isa_enabled) begin
                state_next.exc_return_addr = exc_event.vaddr;
            end else if (exc_event.mode64) begin
                state_next.exc_return_addr = {exc_event.vaddr[63:1], exc_event.isa16};
            end else begin
                state_next.exc_return_addr = {{32{exc_event.vaddr[31]}},
                                              exc_event.vaddr[31:1], exc_event.isa16};
            end
        end
        if (miss_event.valid) begin
            state_next.faulting_vpage_pair = miss_event.vaddr[39:11];
            state_next.xc_region = miss_event.vaddr[63:62];
        end

        // Read channel
        if (state_reg.rvalid && s_axi_rready) begin
            state_next.rvalid = 1'b0;
        end
        if (s_axi_arvalid && state_reg.arready) begin
            state_next.rvalid = 1'b1;
            state_next.rresp  = scr_pkg::RESP_OKAY;
            if (ar_dec[6]) begin
                state_next.rdata = scr_pkg::ZERO32;
                state_next.rresp = scr_pkg::RESP_SLVERR;
            end else begin
                case (ar_dec[5:0])
                    scr_pkg::IDX_EPC_LO:  state_next.rdata = state_reg.exc_return_addr[31:0];
                    scr_pkg::IDX_EPC_HI:  state_next.rdata = state_reg.exc_return_addr[63:32];
                    scr_pkg::IDX_REVISION_IDENTIFIER:    state_next.rdata = revision_identifier_word;
                    scr_pkg::IDX_CONFIG:  state_next.rdata = cfg_word;
                    scr_pkg::IDX_LINKED_LOAD_PHYS:  state_next.rdata = state_reg.linked_load_phys;
                    scr_pkg::IDX_WATCH_LOW_REG: state_next.rdata = state_reg.watch_low_reg;
                    scr_pkg::IDX_WATCH_HIGH_REG: state_next.rdata = state_reg.watch_high_reg;
                    scr_pkg::IDX_XCTX_LO: state_next.rdata = xctx_word[31:0];
                    scr_pkg::IDX_XCTX_HI: state_next.rdata = xctx_word[63:32];
                    default: begin
                        state_next.rdata = scr_pkg::ZERO32;
                        state_next.rresp = scr_pkg::RESP_SLVERR;
                    end
                endcase
            end
        end

        // Ready flags held as flops
        state_next.awready = !state_next.aw_have && !state_next.bvalid;
        state_next.wready  = !state_next.w_have && !state_next.bvalid;
        state_next.arready = !state_next.rvalid;

        // Core-facing outputs
        state_next.kseg0_uncached  = state_next.kseg_zero_coherency == scr_pkg::K0_UNCACHED;
        state_next.watch_exception = watch_hit;
    end

    // ************************************************************
    // State register
    // ************************************************************
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    // Outputs straight from flops
    assign s_axi_awready           = state_reg.awready;
    assign s_axi_wready            = state_reg.wready;
    assign s_axi_bvalid            = state_reg.bvalid;
    assign s_axi_bresp             = state_reg.bresp;
    assign s_axi_arready           = state_reg.arready;
    assign s_axi_rvalid            = state_reg.rvalid;
    assign s_axi_rdata             = state_reg.rdata;
    assign s_axi_rresp             = state_reg.rresp;
    assign exc_return_addr         = state_reg.exc_return_addr;
    assign sixteen_bit_isa_enabled = state_reg.sixteen_bit_isa_enabled;
    assign kseg0_uncached          = state_reg.kseg0_uncached;
    assign watch_exception         = state_reg.watch_exception;

    // ************************************************************
    // Assertions
    // ************************************************************
    property p_ret32;
        @(posedge clk_sys) disable iff (reset)
        (exc_event.valid && sixteen_bit_isa_enabled && !exc_event.mode64)
        |=> exc_return_addr[31:1] == $past(exc_event.vaddr[31:1]);
    endproperty
    a_ret32: assert property (p_ret32) else $error("return address low bits not captured");

    property p_ret64;
        @(posedge clk_sys) disable iff (reset)
        (exc_event.valid && sixteen_bit_isa_enabled && exc_event.mode64)
        |=> exc_return_addr[63:1] == $past(exc_event.vaddr[63:1]);
    endproperty
    a_ret64: assert property (p_ret64) else $error("return address 64-bit not captured");

    property p_mode_bit;
        @(posedge clk_sys) disable iff (reset)
        (exc_event.valid && sixteen_bit_isa_enabled) |=> exc_return_addr[0] == $past(exc_event.isa16);
    endproperty
    a_mode_bit: assert property (p_mode_bit) else $error("mode bit wrong");

    property p_revision_identifier;
        @(posedge clk_sys) disable iff (reset)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_W'({scr_pkg::IDX_REVISION_IDENTIFIER, 2'b00}))
        |=> s_axi_rvalid && s_axi_rdata[7:0] == {REV_MAJ[3:0], REV_MIN[3:0]};
    endproperty
    a_revision_identifier: assert property (p_revision_identifier) else $error("revision read wrong");

    property p_cfg_fixed;
        @(posedge clk_sys) disable iff (reset)
        (s_axi_arvalid && s_axi_arready && s_axi_araddr == ADDR_W'({scr_pkg::IDX_CONFIG, 2'b00}))
        |=> (s_axi_rdata & 32'h806f_fff8) == (scr_pkg::CFG_ONES | 32'h0000_0480);
    endproperty
    a_cfg_fixed: assert property (p_cfg_fixed) else $error("config fixed bits wrong");

    property p_uncached;
        @(posedge clk_sys) disable iff (reset)
        kseg0_uncached == (state_reg.kseg_zero_coherency == scr_pkg::K0_UNCACHED);
    endproperty
    a_uncached: assert property (p_uncached) else $error("kseg0 cache mode wrong");

    property p_watch;
        @(posedge clk_sys) disable iff (reset)
        (mem_access.valid && mem_access.is_load && state_reg.watch_low_reg[scr_pkg::WLO_RD_BIT]
         && mem_access.paddr[35:3] == watch_addr) |=> watch_exception;
    endproperty
    a_watch: assert property (p_watch) else $error("watch exception missed");

    property p_miss;
        @(posedge clk_sys) disable iff (reset)
        miss_event.valid |=> state_reg.faulting_vpage_pair == $past(miss_event.vaddr[39:11]);
    endproperty
    a_miss: assert property (p_miss) else $error("page pair not captured");

    property p_strap_fixed;
        @(posedge clk_sys) disable iff (reset)
        (state_reg.cap_cnt == scr_pkg::SYNC_DONE) |=> $stable(sixteen_bit_isa_enabled)
                                                      && $stable(state_reg.sys_clock_ratio);
    endproperty
    a_strap_fixed: assert property (p_strap_fixed) else $error("strap value changed after capture");

endmodule

// ### hw/scr_pkg.sv
// System-control register bank: shared constants and carrier types.
// Assumes a 32-bit AXI4-Lite register bus and word-indexed register slots.
package scr_pkg;

    // ************************************************************
    // Register indices (byte address is four times the index)
    // ************************************************************
    localparam logic [5:0] IDX_EPC_LO  = 6'h0e;
    localparam logic [5:0] IDX_REVISION_IDENTIFIER    = 6'h0f;
    localparam logic [5:0] IDX_CONFIG  = 6'h10;
    localparam logic [5:0] IDX_LINKED_LOAD_PHYS  = 6'h11;
    localparam logic [5:0] IDX_WATCH_LOW_REG = 6'h12;
    localparam logic [5:0] IDX_WATCH_HIGH_REG = 6'h13;
    localparam logic [5:0] IDX_XCTX_LO = 6'h14;
    localparam logic [5:0] IDX_XCTX_HI = 6'h15;
    localparam logic [5:0] IDX_EPC_HI  = 6'h16;

    // ************************************************************
    // Configuration word fields and fixed bits
    // ************************************************************
    localparam int         CFG_EC_POS   = 28;
    localparam int         CFG_EP_POS   = 24;
    localparam int         CFG_AD_POS   = 23;
    localparam int         CFG_M16_POS  = 20;
    localparam int         CFG_BE_POS   = 15;
    localparam int         CFG_IC_POS   = 9;
    localparam int         CFG_DC_POS   = 6;
    localparam logic [31:0] CFG_ONES    = 32'h0004_5000;
    localparam logic [2:0] CACHE_CODE   = 3'h2;
    localparam logic [2:0] K0_UNCACHED  = 3'h2;
    localparam logic       ENDIAN_LITTLE = 1'b0;

    // Extended context layout: base 63:35, region 34:33, page pair 32:4
    localparam int         XC_VPN_POS   = 4;
    localparam int         XC_R_POS     = 33;
    localparam int         XC_BASE_POS  = 35;

    // Watch register layout
    localparam int         WLO_RD_BIT   = 1;
    localparam int         WLO_WR_BIT   = 0;

    // Zero word, bus response codes and strap capture count
    localparam logic [31:0] ZERO32      = 32'h0000_0000;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
    localparam logic [1:0]  SYNC_DONE   = 2'h3;  // Capture edge is one before this count

    // ************************************************************
    // Carrier types
    // ************************************************************
    typedef struct packed {
        logic        valid;
        logic        isa16;
        logic        mode64;
        logic [63:0] vaddr;
    } scr_exc_event_type;

    typedef struct packed {
        logic        valid;
        logic [63:0] vaddr;
    } scr_miss_event_type;

    typedef struct packed {
        logic        valid;
        logic        is_load;
        logic        is_store;
        logic [35:0] paddr;
    } scr_mem_access_type;

endpackage

// ### tb/scr_regs_tb.sv
// Self-checking bench for the system-control register bank.
// Assumes scr_pkg and scr_regs are compiled first.
`timescale 1ns/1ps
module scr_regs_tb;
    localparam logic [63:0] MISS_VA = 64'h0000_00ab_cdef_1234;
    logic        clk_sys = 1'b0, reset = 1'b1, strap16 = 1'b1;
    logic        awv, wv, bre, arv, rre, awr, wrdy, bv, arr, rv, isa_en, uncached, watch_hit;
    logic [7:0]  awa, ara;
    logic [31:0] wdat, rdat;
    logic [1:0]  bresp, rresp;
    logic [2:0]  ratio = 3'h2;
    logic [63:0] ret_addr, xc;
    int          miscompares = 0, compares = 0, cycles = 0;
    scr_pkg::scr_exc_event_type  exc;
    scr_pkg::scr_miss_event_type miss;
    scr_pkg::scr_mem_access_type mem;

    // ********************************
    // Device and clock
    // ********************************
    scr_regs dut (.clk_sys(clk_sys), .reset(reset), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
        .s_axi_awready(awr), .s_axi_wdata(wdat), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wrdy),
        .s_axi_bresp(bresp), .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
        .s_axi_arready(arr), .s_axi_rdata(rdat), .s_axi_rresp(rresp), .s_axi_rvalid(rv), .s_axi_rready(rre),
        .sixteen_isa_strap(strap16), .clock_ratio_strap(ratio), .exc_event(exc), .miss_event(miss),
        .mem_access(mem), .exc_return_addr(ret_addr), .sixteen_bit_isa_enabled(isa_en),
        .kseg0_uncached(uncached), .watch_exception(watch_hit));

    // Clock toggles every half period
    always #20 clk_sys = ~clk_sys;

    // Hang guard
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            miscompares++;
            stop_test;
        end
    end

    // ********************************
    // Tasks
    // ********************************
    task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
        compares++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t ns: saw %h, expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [5:0] idx, input logic [31:0] d, input logic [1:0] er);
        logic a, w;
        a = 1'b0;
        w = 1'b0;
        @(posedge clk_sys);
        awa <= {idx, 2'h0};
        wdat <= d;
        awv <= 1'b1;
        wv <= 1'b1;
        bre <= 1'b1;
        while (!(a && w)) begin
            @(posedge clk_sys);
            a = a | awr;
            w = w | wrdy;
            if (a) awv <= 1'b0;
            if (w) wv <= 1'b0;
        end
        do @(posedge clk_sys); while (!bv);
        bre <= 1'b0;
        chk(bresp, er);
    endtask

    task automatic rd(input logic [5:0] idx, input logic [31:0] exp, input logic [1:0] er);
        @(posedge clk_sys);
        ara <= {idx, 2'h0};
        arv <= 1'b1;
        rre <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (arr) arv <= 1'b0;
        end while (!rv);
        rre <= 1'b0;
        chk(rdat, exp);
        chk(rresp, er);
    endtask

    task automatic exc_case(input logic i16, input logic m64, input logic [63:0] v, input logic [63:0] exp);
        @(posedge clk_sys);
        exc <= {1'b1, i16, m64, v};
        @(posedge clk_sys);
        exc <= '0;
        @(posedge clk_sys);
        chk(ret_addr, exp);
    endtask

    task automatic stop_test;
        $display("Compares %0d, miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // ********************************
    // Sequence
    // ********************************
    initial begin
        {awv, wv, bre, arv, rre, awa, ara, wdat} = '0;
        exc = '0;
        miss = '0;
        mem = '0;
        repeat (6) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (4) @(posedge clk_sys);
        chk(isa_en, 64'h1);
        rd(scr_pkg::IDX_CONFIG, 32'h2014_5480, scr_pkg::RESP_OKAY);
        wr(scr_pkg::IDX_CONFIG, 32'hffff_ffff, scr_pkg::RESP_OKAY);
        rd(scr_pkg::IDX_CONFIG, 32'h2f94_5487, scr_pkg::RESP_OKAY);
        chk(uncached, 64'h0);
        wr(scr_pkg::IDX_CONFIG, 32'h0000_0002, scr_pkg::RESP_OKAY);
        rd(scr_pkg::IDX_CONFIG, 32'h2014_5482, scr_pkg::RESP_OKAY);
        chk(uncached, 64'h1);
        rd(scr_pkg::IDX_REVISION_IDENTIFIER, 32'h0000_a510, scr_pkg::RESP_OKAY);
        wr(scr_pkg::IDX_REVISION_IDENTIFIER, 32'hffff_ffff, scr_pkg::RESP_OKAY);
        rd(scr_pkg::IDX_REVISION_IDENTIFIER, 32'h0000_a510, scr_pkg::RESP_OKAY);
        wr(scr_pkg::IDX_LINKED_LOAD_PHYS, 32'h8765_4321, scr_pkg::RESP_OKAY);
        rd(scr_pkg::IDX_LINKED_LOAD_PHYS, 32'h8765_4321, scr_pkg::RESP_OKAY);
        rd(6'h17, 32'h0000_0000, scr_pkg::RESP_SLVERR);
        wr(6'h00, 32'h0000_0001, scr_pkg::RESP_SLVERR);
        exc_case(1'b1, 1'b1, 64'h1234_5678_9abc_def0, 64'h1234_5678_9abc_def1);
        exc_case(1'b0, 1'b0, 64'h0000_0000_8765_4321, 64'hffff_ffff_8765_4320);
        rd(scr_pkg::IDX_EPC_LO, 32'h8765_4320, scr_pkg::RESP_OKAY);
        @(posedge clk_sys);
        miss <= {1'b1, MISS_VA};
        @(posedge clk_sys);
        miss <= '0;
        xc = {31'h0, MISS_VA[39:11], 4'h0};
        rd(scr_pkg::IDX_XCTX_LO, xc[31:0], scr_pkg::RESP_OKAY);
        wr(scr_pkg::IDX_XCTX_HI, 32'hffff_fff8, scr_pkg::RESP_OKAY);
        rd(scr_pkg::IDX_XCTX_HI, xc[63:32] | 32'hffff_fff8, scr_pkg::RESP_OKAY);
        wr(scr_pkg::IDX_WATCH_LOW_REG, 32'h0000_1002, scr_pkg::RESP_OKAY);
        wr(scr_pkg::IDX_WATCH_HIGH_REG, 32'h0000_0000, scr_pkg::RESP_OKAY);
        @(posedge clk_sys);
        mem <= {1'b1, 1'b1, 1'b0, 36'h0_0000_1004};
        @(posedge clk_sys);
        mem <= {1'b1, 1'b0, 1'b1, 36'h0_0000_1004};
        @(posedge clk_sys);
        chk(watch_hit, 64'h1);
        mem <= '0;
        @(posedge clk_sys);
        chk(watch_hit, 64'h0);
        stop_test;
    end
endmodule
